// ===== rtl/cikbd_top.sv
// host i/o port handling: indexed config registers and keyboard emulation
// assumes one-cycle rd/wr strobes from the host cycle logic on clk
`timescale 1ns/100ps
`default_nettype none
module cikbd_top
  import cikbd_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // host i/o request
  input  wire cikbd_io_t  io_req,
  // host i/o answer
  output logic [7:0]      io_rdata,
  output logic            io_claim,
  // keyboard emulation outputs
  output logic            addr_line20_gate,
  output logic            cpu_warm_reset_out,
  // port b status inputs, same clock
  input  wire logic [3:0] portb_status
);
  // config array, registers 20h..2ch
  logic [7:0] cfg_q [CFG_COUNT];
  logic [7:0] cfg_d [CFG_COUNT];
  logic [7:0] idx_q, idx_d;         // selected index
  logic       idx_vld_q, idx_vld_d; // index still usable
  logic       arm_q, arm_d;         // a20 sequence armed
  logic       stat_q, stat_d;       // port 60h shows status
  logic       a20_q, a20_d;         // gate state
  logic [3:0] rcnt_q, rcnt_d;       // warm reset counter
  logic [7:0] portb_q, portb_d;     // port b writable bits
  logic [7:0] porta_q, porta_d;     // port a bits
  logic [7:0] rdata_d;

  function automatic logic in_cfg(input logic [7:0] i);
    return (i >= CFG_FIRST) && (i <= CFG_LAST);
  endfunction

  // decoded port hits
  logic hit_idx, hit_dat, hit_k60, hit_k64, hit_pb, hit_pa, sel_ok;
  logic [3:0] slot;
  always_comb begin
    hit_idx = io_req.addr == PORT_INDEX;
    hit_dat = io_req.addr == PORT_DATA;
    hit_k60 = io_req.addr == PORT_KBD_DAT;
    hit_k64 = io_req.addr == PORT_KBD_CMD;
    hit_pb  = io_req.addr == PORT_PORTB;
    hit_pa  = io_req.addr == PORT_PORTA;
    sel_ok  = idx_vld_q && in_cfg(idx_q);
    slot    = 4'(idx_q - CFG_FIRST);
  end

  // next state of all registers
  always_comb begin
    for (int i = 0; i < CFG_COUNT; i++) begin
      cfg_d[i] = cfg_q[i];
    end
    idx_d     = idx_q;
    idx_vld_d = idx_vld_q;
    arm_d     = arm_q;
    stat_d    = stat_q;
    a20_d     = a20_q;
    portb_d   = portb_q;
    porta_d   = porta_q;
    rcnt_d    = (rcnt_q != 4'h0) ? rcnt_q - 4'h1 : 4'h0;
    rdata_d   = io_rdata;
    if (io_req.wr && hit_idx) begin
      idx_d     = io_req.wdata;
      idx_vld_d = 1'b1;
    end
    if ((io_req.wr || io_req.rd) && hit_dat) begin
      if (io_req.wr && sel_ok) begin
        if (idx_q == CFG_REV_IDX) begin
          cfg_d[slot] = io_req.wdata & ~REV_MASK;
        end else begin
          cfg_d[slot] = io_req.wdata;
        end
      end
      idx_vld_d = 1'b0;
    end
    if (io_req.wr && hit_k64) begin
      // any command other than d1h disarms
      arm_d  = io_req.wdata == CMD_WR_OUT;
      stat_d = io_req.wdata == CMD_RD_STAT;
      if (io_req.wdata == CMD_RESET) begin
        rcnt_d = RST_PULSE;
      end
    end
    if (io_req.wr && hit_k60) begin
      if (arm_q) begin
        a20_d = (io_req.wdata & DAT_A20_ON) != 8'h00;
      end
      arm_d = 1'b0;
    end
    // port b and port a writes
    if (io_req.wr && hit_pb) begin
      portb_d = io_req.wdata & PORTB_WMASK;
    end
    if (io_req.wr && hit_pa) begin
      porta_d = io_req.wdata & PORTA_WMASK;
    end
    // read data mux, registered
    if (io_req.rd) begin
      rdata_d = 8'h00;
      if (hit_dat && sel_ok) begin
        rdata_d = cfg_q[slot];
        if (idx_q == CFG_REV_IDX) begin
          rdata_d = {REV_LEVEL, cfg_q[slot][5:0]};
        end
      end else if (hit_idx) begin
        rdata_d = idx_q;
      end else if (hit_k60 && stat_q) begin
        rdata_d[BIT_A20] = a20_q;
        rdata_d[BIT_RST] = rcnt_q != 4'h0;
      end else if (hit_pb) begin
        rdata_d = {4'h0, portb_status} << 4 | portb_q;
      end else if (hit_pa) begin
        rdata_d = porta_q;
      end
    end
  end

  // register all state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < CFG_COUNT; i++) begin
        cfg_q[i] <= 8'h00;
      end
      cfg_q[4'(CFG_IDX21 - CFG_FIRST)] <= CFG21_RESET;
      idx_q     <= 8'h00;
      idx_vld_q <= 1'b0;
      arm_q     <= 1'b0;
      stat_q    <= 1'b0;
      a20_q     <= 1'b0;
      rcnt_q    <= 4'h0;
      portb_q   <= 8'h00;
      porta_q   <= 8'h00;
      io_rdata  <= 8'h00;
    end else begin
      for (int i = 0; i < CFG_COUNT; i++) begin
        cfg_q[i] <= cfg_d[i];
      end
      idx_q     <= idx_d;
      idx_vld_q <= idx_vld_d;
      arm_q     <= arm_d;
      stat_q    <= stat_d;
      a20_q     <= a20_d;
      rcnt_q    <= rcnt_d;
      portb_q   <= portb_d;
      porta_q   <= porta_d;
      io_rdata  <= rdata_d;
    end
  end

  // outputs; port a bit 1 also gates a20 as on later systems
  assign addr_line20_gate   = a20_q | porta_q[BIT_A20];
  assign cpu_warm_reset_out = rcnt_q != 4'h0;
  assign io_claim = (io_req.rd | io_req.wr) &
                    (hit_idx | hit_dat | hit_k60 | hit_k64 | hit_pb | hit_pa);

  chk_index_cleared: assert property (
    @(posedge clk) disable iff (!rst_n)
    (io_req.rd | io_req.wr) && hit_dat && !(io_req.wr && hit_idx)
    |=> !idx_vld_q) else $error("index still valid after data access");
  chk_reset_pulse: assert property (
    @(posedge clk) disable iff (!rst_n)
    io_req.wr && hit_k64 && io_req.wdata == CMD_RESET
    |=> cpu_warm_reset_out [*8] ##1 !cpu_warm_reset_out
      || (io_req.wr && hit_k64))
    else $error("warm reset pulse wrong length");
  chk_a20_set: assert property (
    @(posedge clk) disable iff (!rst_n)
    arm_q && io_req.wr && hit_k60 && io_req.wdata == DAT_A20_ON
    |=> addr_line20_gate) else $error("a20 gate not set");
  chk_a20_unarmed: assert property (
    @(posedge clk) disable iff (!rst_n)
    !arm_q && io_req.wr && hit_k60 |=> a20_q == $past(a20_q))
    else $error("a20 changed while unarmed");
  chk_rev_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    io_req.rd && hit_dat && idx_vld_q && idx_q == CFG_REV_IDX
    |=> io_rdata[7:6] == REV_LEVEL) else $error("revision bits wrong");
  chk_index_load: assert property (
    @(posedge clk) disable iff (!rst_n)
    io_req.wr && hit_idx |=> idx_vld_q && idx_q == $past(io_req.wdata))
    else $error("index not loaded");
  chk_data_path: assert property (
    @(posedge clk) disable iff (!rst_n)
    io_req.wr && hit_dat && sel_ok && idx_q != CFG_REV_IDX
    |=> cfg_q[$past(slot)] == $past(io_req.wdata))
    else $error("config write lost");
  chk_stat_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    io_req.rd && hit_k60 && stat_q
    |=> io_rdata[BIT_A20] == $past(a20_q)
      && io_rdata[BIT_RST] == $past(cpu_warm_reset_out))
    else $error("status bit wrong");
  cov_a20: cover property (@(posedge clk) disable iff (!rst_n)
    arm_q && io_req.wr && hit_k60 && io_req.wdata == DAT_A20_ON);
  cov_reset: cover property (@(posedge clk) disable iff (!rst_n)
    $rose(cpu_warm_reset_out));
  // status read while a warm reset pulse is still running
  cov_stat_read: cover property (@(posedge clk) disable iff (!rst_n)
    io_req.rd && hit_k60 && stat_q && cpu_warm_reset_out);
  cov_cfg_rw: cover property (@(posedge clk) disable iff (!rst_n)
    io_req.rd && hit_dat && sel_ok);
endmodule
`default_nettype wire

// ===== common/cikbd_pkg.sv
// constants and carrier types for the config index / keyboard emulation block
// assumes a host I/O bus of 8-bit data and 8-bit port address on one clock
package cikbd_pkg;
  // i/o port addresses
  localparam logic [7:0] PORT_INDEX   = 8'h22;
  localparam logic [7:0] PORT_DATA    = 8'h24;
  localparam logic [7:0] PORT_KBD_DAT = 8'h60;
  localparam logic [7:0] PORT_PORTB   = 8'h61;
  localparam logic [7:0] PORT_KBD_CMD = 8'h64;
  localparam logic [7:0] PORT_PORTA   = 8'h92;
  // configuration register window
  localparam logic [7:0] CFG_FIRST    = 8'h20;
  localparam int         CFG_COUNT    = 13;
  localparam logic [7:0] CFG_LAST     = 8'h2c;
  localparam logic [7:0] CFG_REV_IDX  = 8'h20;
  localparam logic [7:0] REV_MASK     = 8'hc0;
  localparam logic [1:0] REV_LEVEL    = 2'h0; // arbitrary value
  // index 21h bit 6 resets to one, all else zero
  localparam logic [7:0] CFG21_RESET  = 8'h40;
  localparam logic [7:0] CFG_IDX21    = 8'h21;
  // keyboard controller commands and data
  localparam logic [7:0] CMD_WR_OUT   = 8'hd1;
  localparam logic [7:0] CMD_RD_STAT  = 8'hd0;
  localparam logic [7:0] CMD_RESET    = 8'hfe;
  localparam logic [7:0] DAT_A20_ON   = 8'h02;
  localparam int         BIT_A20      = 1;
  localparam int         BIT_RST      = 0;
  // port b writable bits 3:0, port a bits 1:0
  localparam logic [7:0] PORTB_WMASK  = 8'h0f;
  localparam logic [7:0] PORTA_WMASK  = 8'h03;
  // warm reset pulse width in cycles
  localparam logic [3:0] RST_PULSE    = 4'h8;

  // one host i/o request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cikbd_io_t;
endpackage

// ===== sim/cikbd_host.sv
// host cpu model: issues byte i/o cycles to the block
// assumes the block takes a strobe at the next rising clk edge
`timescale 1ns/100ps
`default_nettype none
module cikbd_host
  import cikbd_pkg::*;
(
  // clock
  input  wire logic       clk,
  // request out
  output var cikbd_io_t   io_req,
  // answer in
  input  wire logic [7:0] io_rdata,
  input  wire logic       io_claim
);
  // idle bus at time zero
  initial io_req = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};

  // one strobe from falling edge, held over the taking edge
  task automatic cyc(input logic w, input logic [7:0] a,
                     input logic [7:0] d, output logic [7:0] q,
                     output logic c);
    @(negedge clk);
    io_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    c = io_claim;
    @(negedge clk);
    // released lines show the inverse so stale values never match
    io_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    q = io_rdata;
  endtask

  task automatic cfg(input logic w, input logic [7:0] i,
                     input logic [7:0] d, output logic [7:0] q);
    logic c;
    cyc(1'b1, PORT_INDEX, i, q, c);
    cyc(w, PORT_DATA, d, q, c);
  endtask
endmodule
`default_nettype wire

// ===== sim/config_index_kbd_emulation_bench.sv
// self-checking bench for the config index / keyboard emulation block
// assumes the host model drives all requests on the falling edge
`timescale 1ns/100ps
`default_nettype none
module config_index_kbd_emulation_bench;
  import cikbd_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  cikbd_io_t  io_req;
  logic [7:0] io_rdata;
  logic       io_claim, gate, wrst;
  logic [3:0] portb_status = 4'h0;
  int         n_mismatch = 0, compares = 0, cycles = 0;
  logic [15:0] rnd = 16'hb61b; // seed 46619
  localparam logic [7:0] PORTS [7] = '{PORT_INDEX, PORT_DATA,
    PORT_KBD_DAT, PORT_PORTB, PORT_KBD_CMD, PORT_PORTA, 8'h80};

  always #25 clk = ~clk;

  cikbd_top uut (.clk(clk), .rst_n(rst_n), .io_req(io_req),
    .io_rdata(io_rdata), .io_claim(io_claim), .addr_line20_gate(gate),
    .cpu_warm_reset_out(wrst), .portb_status(portb_status));
  cikbd_host host (.clk(clk), .io_req(io_req), .io_rdata(io_rdata),
    .io_claim(io_claim));

  function automatic logic [15:0] xs(input logic [15:0] x);
    x = x ^ (x << 7);
    x = x ^ (x >> 9);
    return x ^ (x << 8);
  endfunction
  // revision bits read back fixed, the rest as written
  function automatic logic [7:0] exp_cfg(input logic [7:0] i, d);
    return (i == CFG_REV_IDX) ? {REV_LEVEL, d[5:0]} : d;
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, g);
    compares++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  task automatic complete_run();
    if (n_mismatch == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic kw(input logic [7:0] a, d); // plain port write
    logic [7:0] q;
    logic       c;
    host.cyc(1'b1, a, d, q, c);
  endtask

  // hang guard, the run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      complete_run();
    end
  end

  initial begin
    logic [7:0] q, d;
    logic       c;
    int         n;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    host.cfg(1'b0, CFG_REV_IDX, 8'h00, q);
    chk("cfg20 reset", {REV_LEVEL, 6'h00}, q);
    host.cfg(1'b0, CFG_IDX21, 8'h00, q);
    chk("cfg21 reset", CFG21_RESET, q);
    for (int i = 0; i < CFG_COUNT; i++) begin
      rnd = xs(rnd);
      d = (i == 0) ? 8'hff : rnd[7:0];
      host.cfg(1'b1, CFG_FIRST + 8'(i), d, q);
      host.cfg(1'b0, CFG_FIRST + 8'(i), 8'h00, q);
      chk("cfg readback", exp_cfg(CFG_FIRST + 8'(i), d), q);
    end
    host.cfg(1'b1, CFG_LAST + 8'h01, 8'ha5, q);
    host.cfg(1'b0, CFG_LAST + 8'h01, 8'h00, q);
    chk("cfg outside", 8'h00, q);
    host.cfg(1'b1, 8'h25, 8'h5a, q);
    host.cyc(1'b1, PORT_INDEX, 8'h25, q, c);
    host.cyc(1'b0, PORT_DATA, 8'h00, q, c);
    chk("cfg25 read", 8'h5a, q);
    host.cyc(1'b0, PORT_DATA, 8'h00, q, c);
    chk("stale read", 8'h00, q);
    host.cyc(1'b1, PORT_DATA, 8'h11, q, c);
    host.cfg(1'b0, 8'h25, 8'h00, q);
    chk("stale write", 8'h5a, q);
    foreach (PORTS[i]) begin
      host.cyc(1'b0, PORTS[i], 8'h00, q, c);
      chk("claim", {7'h00, i < 6}, {7'h00, c});
    end
    rnd = xs(rnd);
    portb_status = rnd[3:0];
    kw(PORT_PORTB, 8'hff);
    host.cyc(1'b0, PORT_PORTB, 8'h00, q, c);
    chk("port b", {portb_status, 4'hf}, q);
    kw(PORT_KBD_CMD, CMD_WR_OUT);
    kw(PORT_KBD_DAT, DAT_A20_ON);
    chk("a20 on", 8'h01, {7'h00, gate});
    kw(PORT_KBD_CMD, CMD_RD_STAT);
    host.cyc(1'b0, PORT_KBD_DAT, 8'h00, q, c);
    chk("status", 8'h02, q);
    kw(PORT_KBD_CMD, CMD_WR_OUT);
    host.cyc(1'b0, PORT_KBD_DAT, 8'h00, q, c);
    chk("status hidden", 8'h00, q);
    kw(PORT_KBD_DAT, 8'h00);
    chk("a20 off", 8'h00, {7'h00, gate});
    kw(PORT_KBD_CMD, CMD_WR_OUT);
    kw(PORT_KBD_CMD, CMD_RD_STAT);
    kw(PORT_KBD_DAT, DAT_A20_ON);
    chk("a20 disarmed", 8'h00, {7'h00, gate});
    kw(PORT_PORTA, 8'h02);
    chk("port a a20", 8'h01, {7'h00, gate});
    kw(PORT_PORTA, 8'h00);
    kw(PORT_KBD_CMD, CMD_RESET);
    n = 0;
    while (wrst === 1'b1 && n < 20) begin
      n++;
      @(negedge clk);
    end
    chk("reset width", {4'h0, RST_PULSE}, 8'(n));
    kw(PORT_KBD_CMD, CMD_RESET);
    kw(PORT_KBD_CMD, CMD_RD_STAT);
    host.cyc(1'b0, PORT_KBD_DAT, 8'h00, q, c);
    chk("reset status", 8'h01, q);
    // second reset in mid-run, cutting a live warm reset pulse
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk("reset cut", 8'h00, {7'h00, wrst});
    host.cfg(1'b0, CFG_IDX21, 8'h00, q);
    chk("cfg21 again", CFG21_RESET, q);
    complete_run();
  end
endmodule
`default_nettype wire
